// >>> test_usb_if_flag_port_status.sv
// Self-checking bench for the flag port status block
`timescale 1ns/10ps
`default_nettype none
module test_usb_if_flag_port_status
  import ufp_pkg::*;
;
  logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, fa, fb, fc, fd, strobe, pd_dis, are, irq;
  logic [4:0] ep_port;
  logic [2:0] conf;
  logic [1:0] filt;
  ufp_rx_s rx;
  int n_fail = 0, compares = 0;
  logic [31:0] rd_q[$];
  logic [4:0] ep_q[$];
  logic [7:0] offs [6] = '{OFF_PORT_MASKS, OFF_FRAME_COUNTER, OFF_ENDPOINT_TAG,
    OFF_OTG_EVENT_MASK, OFF_POWER_SIGNAL, OFF_PHY_CONTROL};
  logic [31:0] msk [6] = '{32'hffffffff, FRAME_WMASK, EPTAG_WMASK, 32'hffffffff,
    POWER_WMASK, PHY_CTRL_WMASK};
  logic [31:0] d;
  initial forever #20 pclk = ~pclk;
  ufp_flag_port_status #(.FLT_MAX_LOG2(4)) u_ufp_flag_port_status (.pclk(pclk),
    .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_in(rx), .flag_port_a(fa), .flag_port_b(fb), .flag_port_c(fc), .flag_port_d(fd),
    .rx_endpoint_port(ep_port), .rx_endpoint_strobe(strobe), .phy_pulldown_disable(pd_dis),
    .phy_config_pins(conf), .auto_resume_enable(are), .linestate_filt(filt), .irq(irq));
  ufp_phy_model u_ufp_phy_model (.pclk(pclk), .rx_in(rx));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
    input logic [31:0] exp);
    int k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    if (!w) rd_q.push_back(exp);
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_fail++;
      end_sim();
    end
    check(32'(pslverr), 32'(a > OFF_LINE_STATUS));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) check(prdata, rd_q.pop_front());
    if (strobe === 1'b1) check(32'(ep_port), 32'(ep_q.pop_front()));
  end
  initial begin
    void'($urandom(78));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) apb(0, 8'h24 + 8'(4 * i), 0, 0);
    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      apb(1, offs[i], d, 0);
      apb(0, offs[i], 0, d & msk[i]);
    end
    check(32'(pd_dis), 32'(d[18]));
    check(32'({are, conf}), 32'(d[7:4]));
    apb(1, OFF_LAST_PACKET_ID, $urandom, 0);
    apb(0, OFF_LAST_PACKET_ID, 0, 0);
    apb(1, 8'h80, $urandom, 0);
    apb(0, 8'h80, 0, 0);
    apb(1, OFF_PHY_CONTROL, 32'h0200, 0);
    apb(1, OFF_ENDPOINT_TAG, 32'h0020, 0);
    apb(1, OFF_PORT_MASKS, 32'h4000_0040, 0);
    ep_q.push_back(5'h15);
    u_ufp_phy_model.packet(4'ha, 4'h5, 1'b1);
    repeat (2) @(posedge pclk);
    check(32'({fa, fb, fc, fd}), 32'h9);
    apb(0, OFF_LAST_PACKET_ID, 0, 32'ha);
    apb(0, OFF_LAST_ENDPOINT, 0, 32'h15);
    apb(0, OFF_LINE_EVENT_FLAGS, 0, 32'h40);
    ep_q.push_back(5'h03);
    u_ufp_phy_model.packet(4'h3, 4'h3, 1'b0);
    repeat (2) @(posedge pclk);
    check(32'(fa), 0);
    apb(1, OFF_IRQ_STATUS, 32'h7, 0);
    u_ufp_phy_model.resume(1'b0);
    apb(0, OFF_PHY_CONTROL, 0, 32'h2200);
    check(32'(irq), 0);
    apb(1, OFF_IRQ_MASK, 32'h2, 0);
    repeat (2) @(posedge pclk);
    check(32'(irq), 1);
    apb(1, OFF_IRQ_STATUS, 32'h2, 0);
    repeat (2) @(posedge pclk);
    check(32'(irq), 0);
    apb(1, OFF_PHY_CONTROL, 32'h0200, 0);
    u_ufp_phy_model.resume(1'b1);
    apb(0, OFF_PHY_CONTROL, 0, 32'h1200);
    // Frozen clock enable: a resume pulse in that window must be lost
    clk_en <= 1'b0;
    u_ufp_phy_model.resume(1'b0);
    clk_en <= 1'b1;
    apb(0, OFF_PHY_CONTROL, 0, 32'h1200);
    u_ufp_phy_model.line(LS_K, 3);
    u_ufp_phy_model.line(LS_J, 8);
    check(32'(filt), 32'(LS_J));
    u_ufp_phy_model.line(LS_K, 8);
    check(32'(filt), 32'(LS_K));
    apb(0, OFF_LINE_STATUS, 0, 32'(LS_K));
    end_sim();
  end
endmodule
`default_nettype wire

// >>> ufp_flag_port_status.sv
// Flag routing, frame counter, last packet capture and PHY control registers
`timescale 1ns/10ps
`default_nettype none

module ufp_flag_port_status
  import ufp_pkg::*;
#(
  parameter int unsigned FLT_MAX_LOG2 = 15
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ufp_rx_s rx_in,
  output logic flag_port_a,
  output logic flag_port_b,
  output logic flag_port_c,
  output logic flag_port_d,
  output logic [4:0] rx_endpoint_port,
  output logic rx_endpoint_strobe,
  output logic phy_pulldown_disable,
  output logic [2:0] phy_config_pins,
  output logic auto_resume_enable,
  output logic [1:0] linestate_filt,
  output logic irq
);

  logic [31:0] flag_port_masks;
  logic [FRAME_W-1:0] frame_counter;
  logic [3:0] last_packet_id;
  logic [3:0] last_endpoint;
  logic last_endpoint_valid;
  logic [NUM_EP-1:0] endpoint_tag_select;
  logic [31:0] otg_event_mask;
  logic [8:0] power_signal_word;
  logic [31:0] phy_control;
  logic [NUM_FLAGS-1:0] line_event_flags;
  logic [NUM_FLAGS-1:0] sticky_select;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [1:0] ls_candidate;
  logic [FLT_CNT_W-1:0] ls_count;
  logic [NUM_FLAGS-1:0] flag_events;
  logic [NUM_PORTS-1:0] next_port;
  logic [FLT_CNT_W-1:0] flt_limit;
  logic ls_commit;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] rd_word;
  logic [IRQ_W-1:0] irq_events;

  assign wr_en = psel && penable && pwrite && clk_en;
  // Read data is fetched in the setup phase so it stands in the access phase
  assign rd_en = psel && !penable && !pwrite;

  always_comb begin
    addr_ok = 1'b1;
    rd_word = ZERO_WORD;
    unique case (paddr)
      OFF_PORT_MASKS: rd_word = flag_port_masks;
      OFF_FRAME_COUNTER: rd_word = {21'h0, frame_counter};
      OFF_LAST_PACKET_ID: rd_word = {28'h0, last_packet_id};
      OFF_LAST_ENDPOINT: rd_word = {27'h0, last_endpoint_valid, last_endpoint};
      OFF_ENDPOINT_TAG: rd_word = {16'h0, endpoint_tag_select};
      OFF_OTG_EVENT_MASK: rd_word = otg_event_mask;
      OFF_POWER_SIGNAL: rd_word = {23'h0, power_signal_word};
      OFF_PHY_CONTROL: rd_word = phy_control & PHY_CTRL_WMASK;
      OFF_LINE_EVENT_FLAGS: rd_word = {25'h0, line_event_flags};
      OFF_STICKY_SELECT: rd_word = {25'h0, sticky_select};
      OFF_IRQ_STATUS: rd_word = {29'h0, irq_status};
      OFF_IRQ_MASK: rd_word = {29'h0, irq_mask};
      OFF_LINE_STATUS: rd_word = {30'h0, linestate_filt};
      default: addr_ok = 1'b0;
    endcase
  end

  // Zero wait states; unmapped offsets answer with an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= ZERO_WORD;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (rd_en) begin
        prdata <= rd_word;
      end
    end
  end

  // Registered one cycle after the setup phase, so access completes in phase two
  logic acc_wr;
  assign acc_wr = wr_en && pready && addr_ok;

  logic [NUM_FLAGS-1:0] flag_clear;
  assign flag_clear = (acc_wr && paddr == OFF_LINE_EVENT_FLAGS) ? pwdata[NUM_FLAGS-1:0] : '0;

  // Bit 7 of each mask byte has no flag behind it and is kept for readback only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_port_masks <= ZERO_WORD;
    end else if (acc_wr && paddr == OFF_PORT_MASKS) begin
      flag_port_masks <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      endpoint_tag_select <= '0;
    end else if (acc_wr && paddr == OFF_ENDPOINT_TAG) begin
      endpoint_tag_select <= pwdata[NUM_EP-1:0];
    end
  end

  // Held for software only; nothing in this block reads it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      otg_event_mask <= ZERO_WORD;
    end else if (acc_wr && paddr == OFF_OTG_EVENT_MASK) begin
      otg_event_mask <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_signal_word <= '0;
    end else if (acc_wr && paddr == OFF_POWER_SIGNAL) begin
      power_signal_word <= pwdata[PWR_VALID_BIT:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sticky_select <= '0;
    end else if (acc_wr && paddr == OFF_STICKY_SELECT) begin
      sticky_select <= pwdata[NUM_FLAGS-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= '0;
    end else if (acc_wr && paddr == OFF_IRQ_MASK) begin
      irq_mask <= pwdata[IRQ_W-1:0];
    end
  end

  // Frame counter is a plain register; no logic here advances it, it is software-owned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_counter <= '0;
    end else if (acc_wr && paddr == OFF_FRAME_COUNTER) begin
      frame_counter <= pwdata[FRAME_W-1:0];
    end
  end

  // PHY control; hardware resume flags win over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phy_control <= ZERO_WORD;
    end else if (clk_en) begin
      if (acc_wr && paddr == OFF_PHY_CONTROL) begin
        phy_control <= pwdata & PHY_CTRL_WMASK;
      end
      if (rx_in.resume_se0) begin
        phy_control[PHY_RES_SE0_BIT] <= 1'b1;
      end
      if (rx_in.resume_k) begin
        phy_control[PHY_RES_K_BIT] <= 1'b1;
      end
    end
  end

  // Linestate filter: candidate must hold 2^N clocks before it is committed
  // N above the cap acts as the cap, keeping the counter narrow
  always_comb begin
    flt_limit = '0;
    if (phy_control[PHY_FILT_MSB:PHY_FILT_LSB] > 4'(FLT_MAX_LOG2)) begin
      flt_limit[FLT_MAX_LOG2] = 1'b1;
    end else begin
      flt_limit[phy_control[PHY_FILT_MSB:PHY_FILT_LSB]] = 1'b1;
    end
  end

  // Only a candidate that differs from the output commits, so each change flags once
  assign ls_commit = (rx_in.linestate == ls_candidate) && (ls_candidate != linestate_filt)
    && (ls_count + 1'b1 >= flt_limit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls_candidate <= LS_SE0;
      ls_count <= '0;
      linestate_filt <= LS_SE0;
    end else if (clk_en) begin
      if (rx_in.linestate != ls_candidate) begin
        ls_candidate <= rx_in.linestate;
        ls_count <= '0;
      end else if (ls_commit) begin
        linestate_filt <= ls_candidate;
      end else if (ls_count < flt_limit) begin
        ls_count <= ls_count + 1'b1;
      end
    end
  end

  always_comb begin
    flag_events = '0;
    flag_events[FL_TOKEN] = rx_in.token_ok;
    flag_events[FL_SE0] = ls_commit && ls_candidate == LS_SE0;
    flag_events[FL_K] = ls_commit && ls_candidate == LS_K;
    flag_events[FL_J] = ls_commit && ls_candidate == LS_J;
    flag_events[FL_CRC16] = rx_in.crc16_fail;
    flag_events[FL_RXACT] = rx_in.rx_active;
    flag_events[FL_RXERR] = rx_in.rx_error;
  end

  // Per flag: set wins, sticky bits clear on write-one, normal bits on next packet, except non-sticky FL_RXACT and FL_RXERR, which follow their input
  generate
    for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          line_event_flags[i] <= 1'b0;
        end else if (clk_en) begin
          if (i == FL_RXACT || i == FL_RXERR) begin
            if (flag_events[i] || !sticky_select[i]) begin
              line_event_flags[i] <= flag_events[i];
            end else if (flag_clear[i]) begin
              line_event_flags[i] <= 1'b0;
            end
          end else if (flag_events[i]) begin
            line_event_flags[i] <= 1'b1;
          end else if (sticky_select[i]) begin
            if (flag_clear[i]) begin
              line_event_flags[i] <= 1'b0;
            end
          end else if (rx_in.packet_start) begin
            line_event_flags[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      next_port[p] = |(flag_port_masks[p*MASK_W +: NUM_FLAGS] & line_event_flags);
    end
  end

  // One flop stage after the flags, so ports lag the flag register by a cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_port_a <= 1'b0;
      flag_port_b <= 1'b0;
      flag_port_c <= 1'b0;
      flag_port_d <= 1'b0;
    end else if (clk_en) begin
      flag_port_a <= next_port[0];
      flag_port_b <= next_port[1];
      flag_port_c <= next_port[2];
      flag_port_d <= next_port[3];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_packet_id <= '0;
    end else if (clk_en && rx_in.pid_valid) begin
      last_packet_id <= rx_in.pid;
    end
  end

  // An identifier without an endpoint keeps the old number but marks it stale
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_endpoint <= '0;
      last_endpoint_valid <= 1'b0;
    end else if (clk_en) begin
      if (rx_in.ep_valid) begin
        last_endpoint <= rx_in.ep;
        last_endpoint_valid <= 1'b1;
      end else if (rx_in.pid_valid) begin
        last_endpoint_valid <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_endpoint_port <= '0;
      rx_endpoint_strobe <= 1'b0;
    end else if (clk_en) begin
      rx_endpoint_strobe <= rx_in.ep_valid;
      if (rx_in.ep_valid) begin
        if (endpoint_tag_select[rx_in.ep]) begin
          rx_endpoint_port <= {1'b0, rx_in.ep} | EP_TAG_OR;
        end else begin
          rx_endpoint_port <= {1'b0, rx_in.ep};
        end
      end
    end
  end

  // Pin copies lag the control register by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phy_pulldown_disable <= 1'b0;
      phy_config_pins <= '0;
      auto_resume_enable <= 1'b0;
    end else if (clk_en) begin
      phy_pulldown_disable <= phy_control[PHY_PD_DIS_BIT];
      phy_config_pins <= phy_control[PHY_CONF_MSB:PHY_CONF_LSB];
      auto_resume_enable <= phy_control[PHY_AUTO_RES_BIT];
    end
  end

  always_comb begin
    irq_events = '0;
    irq_events[IRQ_FLAG] = |flag_events;
    irq_events[IRQ_RES_SE0] = rx_in.resume_se0;
    irq_events[IRQ_RES_K] = rx_in.resume_k;
  end

  // Set wins over a write-one clear arriving in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
    end else if (clk_en) begin
      if (acc_wr && paddr == OFF_IRQ_STATUS) begin
        irq_status <= (irq_status & ~pwdata[IRQ_W-1:0]) | irq_events;
      end else begin
        irq_status <= irq_status | irq_events;
      end
    end
  end

  // Level output follows the status one cycle late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule
`default_nettype wire

// >>> ufp_flag_port_status_properties.sv
// Port-level checker for the flag port status block
`timescale 1ns/10ps
`default_nettype none
module ufp_props
  import ufp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire ufp_rx_s rx_in,
  input wire logic [4:0] rx_endpoint_port,
  input wire logic rx_endpoint_strobe,
  input wire logic phy_pulldown_disable,
  input wire logic [2:0] phy_config_pins,
  input wire logic auto_resume_enable,
  input wire logic [1:0] linestate_filt
);
  default clocking @(posedge pclk); endclocking
  // Frozen cycles stretch every latency, so they are left out
  default disable iff (!presetn || !clk_en);
  logic phy_wr;
  assign phy_wr = psel && penable && pready && pwrite && paddr == OFF_PHY_CONTROL;
  a_setup_answered: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_pready_single: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_unmapped_err: assert property (psel && penable && pready && paddr > OFF_LINE_STATUS |-> pslverr)
    else $error("unmapped access not refused");
  a_config_copy: assert property (phy_wr |-> ##2 phy_config_pins == $past(pwdata[6:4], 2))
    else $error("config pins differ from control");
  a_pulldown_copy: assert property (phy_wr |-> ##2 phy_pulldown_disable == $past(pwdata[18], 2))
    else $error("pulldown disable differs");
  a_resume_copy: assert property (phy_wr |-> ##2 auto_resume_enable == $past(pwdata[7], 2))
    else $error("auto resume enable differs");
  a_strobe_cause: assert property (rx_endpoint_strobe |-> $past(rx_in.ep_valid))
    else $error("endpoint strobe without valid endpoint");
  a_ep_number: assert property (rx_endpoint_strobe |-> rx_endpoint_port[3:0] == $past(rx_in.ep))
    else $error("endpoint number wrong");
  a_filter_source: assert property ($changed(linestate_filt) |-> linestate_filt == $past(rx_in.linestate))
    else $error("filtered linestate not from input");
  c_phy_write: cover property (phy_wr);
  c_tagged_ep: cover property (rx_endpoint_strobe && rx_endpoint_port[4]);
  c_filter_move: cover property ($changed(linestate_filt));
endmodule
bind ufp_flag_port_status ufp_props u_props (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .rx_in(rx_in), .rx_endpoint_port(rx_endpoint_port),
  .rx_endpoint_strobe(rx_endpoint_strobe), .phy_pulldown_disable(phy_pulldown_disable),
  .phy_config_pins(phy_config_pins), .auto_resume_enable(auto_resume_enable),
  .linestate_filt(linestate_filt));
`default_nettype wire

// >>> ufp_phy_model.sv
// Behavioural USB PHY side driving the receive bundle
`timescale 1ns/10ps
`default_nettype none
module ufp_phy_model
  import ufp_pkg::*;
(
  input wire logic pclk,
  output var ufp_rx_s rx_in
);
  initial begin
    rx_in = '0;
    rx_in.linestate = LS_J;
  end
  // Released identifiers are inverted so stale values never look valid
  task automatic packet(input logic [3:0] pid, input logic [3:0] ep, input logic tok);
    @(posedge pclk);
    rx_in.packet_start <= 1'b1;
    @(posedge pclk);
    rx_in.packet_start <= 1'b0;
    rx_in.token_ok <= tok;
    rx_in.pid_valid <= 1'b1;
    rx_in.pid <= pid;
    rx_in.ep_valid <= 1'b1;
    rx_in.ep <= ep;
    @(posedge pclk);
    rx_in.token_ok <= 1'b0;
    rx_in.pid_valid <= 1'b0;
    rx_in.ep_valid <= 1'b0;
    rx_in.pid <= ~pid;
    rx_in.ep <= ~ep;
  endtask
  task automatic resume(input logic k);
    @(posedge pclk);
    rx_in.resume_se0 <= !k;
    rx_in.resume_k <= k;
    @(posedge pclk);
    rx_in.resume_se0 <= 1'b0;
    rx_in.resume_k <= 1'b0;
  endtask
  task automatic line(input logic [1:0] ls, input int n);
    @(posedge pclk);
    rx_in.linestate <= ls;
    repeat (n - 1) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// >>> ufp_pkg.sv
// Package: register map, field positions and carrier types for the flag port status block
package ufp_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_PORT_MASKS = 8'h24;
  localparam logic [7:0] OFF_FRAME_COUNTER = 8'h28;
  localparam logic [7:0] OFF_LAST_PACKET_ID = 8'h2c;
  localparam logic [7:0] OFF_LAST_ENDPOINT = 8'h30;
  localparam logic [7:0] OFF_ENDPOINT_TAG = 8'h34;
  localparam logic [7:0] OFF_OTG_EVENT_MASK = 8'h38;
  localparam logic [7:0] OFF_POWER_SIGNAL = 8'h3c;
  localparam logic [7:0] OFF_PHY_CONTROL = 8'h40;
  localparam logic [7:0] OFF_LINE_EVENT_FLAGS = 8'h44;
  localparam logic [7:0] OFF_STICKY_SELECT = 8'h48;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h4c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h50;
  localparam logic [7:0] OFF_LINE_STATUS = 8'h54;

  localparam int unsigned NUM_FLAGS = 7;
  localparam int unsigned NUM_PORTS = 4;
  localparam int unsigned MASK_W = 8;
  localparam int unsigned FRAME_W = 11;
  localparam int unsigned NUM_EP = 16;
  localparam int unsigned EP_VALID_BIT = 4;
  localparam logic [4:0] EP_TAG_OR = 5'h10;
  localparam int unsigned PWR_VALID_BIT = 8;
  localparam int unsigned PHY_PD_DIS_BIT = 18;
  localparam int unsigned PHY_RES_SE0_BIT = 13;
  localparam int unsigned PHY_RES_K_BIT = 12;
  localparam int unsigned PHY_FILT_LSB = 8;
  localparam int unsigned PHY_FILT_MSB = 11;
  localparam int unsigned PHY_AUTO_RES_BIT = 7;
  localparam int unsigned PHY_CONF_LSB = 4;
  localparam int unsigned PHY_CONF_MSB = 6;
  localparam logic [31:0] PHY_CTRL_WMASK = 32'h0004_3ff0;
  localparam logic [31:0] FRAME_WMASK = 32'h0000_07ff;
  localparam logic [31:0] POWER_WMASK = 32'h0000_01ff;
  localparam logic [31:0] EPTAG_WMASK = 32'h0000_ffff;
  localparam logic [31:0] FLAGS_WMASK = 32'h0000_007f;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam int unsigned FLT_CNT_W = 16;

  localparam int unsigned FL_TOKEN = 6;
  localparam int unsigned FL_SE0 = 5;
  localparam int unsigned FL_K = 4;
  localparam int unsigned FL_J = 3;
  localparam int unsigned FL_CRC16 = 2;
  localparam int unsigned FL_RXACT = 1;
  localparam int unsigned FL_RXERR = 0;

  localparam logic [1:0] LS_SE0 = 2'h0;
  localparam logic [1:0] LS_J = 2'h1;
  localparam logic [1:0] LS_K = 2'h2;

  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_FLAG = 0;
  localparam int unsigned IRQ_RES_SE0 = 1;
  localparam int unsigned IRQ_RES_K = 2;

  typedef struct packed {
    logic token_ok;
    logic crc16_fail;
    logic packet_start;
    logic pid_valid;
    logic [3:0] pid;
    logic ep_valid;
    logic [3:0] ep;
    logic rx_active;
    logic rx_error;
    logic [1:0] linestate;
    logic resume_se0;
    logic resume_k;
  } ufp_rx_s;
endpackage
